//--- rtl/mpsq_host.sv
// Function
// - Modem standby uses L1.2 or L2 sequence
// - Sleep/off shutdown; wake/cold boot start-up
// - Warm boot uses power-cycling reset
// - Firmware upgrade uses powered reset
// - Module link is x1, Gen2, Gen1 compatible
// - Fundamental reset low resets module link
// - Core dump: fundamental reset resets everything
// - Module pulls clock request to get refclk
// - Either side may pull clock request
// - Module pulls open-drain wake low
// - Start-up: reset 8ms, PERST 50ms, PERST last
// - Shutdown: reset 16ms, power-off 2ms later
// - Powered reset holds reset over 2ms
// - Power-cycle keeps power off 500ms
`default_nettype none
module mpsq_host
    import mpsq_pkg::*;
#(
    parameter int unsigned ON1_CYC  = T_ON1_MS * CYC_PER_MS,
    parameter int unsigned ON2_CYC  = T_ON2_MS * CYC_PER_MS,
    parameter int unsigned OFF1_CYC = T_OFF1_MS * CYC_PER_MS,
    parameter int unsigned OFF2_CYC = T_OFF2_MS * CYC_PER_MS,
    parameter int unsigned OFF_CYC  = T_OFF_MS * CYC_PER_MS,
    parameter int unsigned RST_CYC  = T_RST_MS * CYC_PER_MS + 1
)
(
    input  wire logic      core_clk_i,
    input  wire logic      rst_b_i,
    input  wire logic      seq_req_i,
    input  wire mpsq_seq_t seq_sel_i,
    input  wire logic      clk_need_i,
    output logic           busy_o,
    output logic           done_o,
    output logic           clkreq_seen_o,
    output logic           wake_seen_o,
    mpsq_if.host           lnk
);

    mpsq_host_st_t r_r;
    mpsq_host_st_t r_nxt;

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_comb
    begin
        r_nxt = r_r;
        r_nxt.done = 1'b0;
        r_nxt.cnt  = r_r.cnt + 32'h1;
        r_nxt.need = clk_need_i;
        r_nxt.ck_s = {r_r.ck_s[0], ~lnk.clkreq_n};
        r_nxt.wk_s = {r_r.wk_s[0], ~lnk.link_wake_request_n};
        case (r_r.st)
            H_IDLE:
            begin
                r_nxt.cnt = 32'h0;
                // Requests are only looked at here, so a busy sequencer drops them
                if (seq_req_i)
                begin
                    case (seq_sel_i)
                        SEQ_START:
                        begin
                            r_nxt.fpo_n = 1'b1;
                            r_nxt.st    = H_ON_RST;
                        end
                        SEQ_SHUTDOWN:
                        begin
                            r_nxt.perst_n = 1'b0;
                            r_nxt.cyc     = 1'b0;
                            r_nxt.st      = H_OFF_RST;
                        end
                        SEQ_RST_PWR:
                        begin
                            r_nxt.perst_n = 1'b0;
                            r_nxt.cyc     = 1'b1;
                            r_nxt.st      = H_OFF_RST;
                        end
                        SEQ_RST_KEEP:
                        begin
                            r_nxt.rst_n = 1'b0;
                            r_nxt.st    = H_RST_HOLD;
                        end
                        SEQ_L2_ENTER:
                        begin
                            r_nxt.perst_n = 1'b0;
                            r_nxt.done    = 1'b1;
                        end
                        SEQ_L2_EXIT:
                        begin
                            r_nxt.perst_n = 1'b1;
                            r_nxt.done    = 1'b1;
                        end
                        SEQ_L12_ENTER:
                        begin
                            r_nxt.own_clk = 1'b0;
                            r_nxt.done    = 1'b1;
                        end
                        SEQ_L12_EXIT:
                        begin
                            r_nxt.own_clk = 1'b1;
                            r_nxt.done    = 1'b1;
                        end
                        default:
                        begin
                            r_nxt.done = 1'b0;
                        end
                    endcase
                end
            end
            H_ON_RST:
            begin
                if (r_r.cnt == 32'(ON1_CYC - 1))
                begin
                    r_nxt.rst_n = 1'b1;
                    r_nxt.st    = H_ON_PERST;
                end
            end
            H_ON_PERST:
            begin
                // Counter keeps running from the power-on edge, so both
                // delays are measured from the same point
                if (r_r.cnt == 32'(ON2_CYC - 1))
                begin
                    r_nxt.perst_n = 1'b1;
                    r_nxt.st      = H_IDLE;
                    r_nxt.done    = 1'b1;
                end
            end
            H_OFF_RST:
            begin
                if (r_r.cnt == 32'(OFF1_CYC - 1))
                begin
                    r_nxt.rst_n = 1'b0;
                    r_nxt.cnt   = 32'h0;
                    r_nxt.st    = H_OFF_FPO;
                end
            end
            H_OFF_FPO:
            begin
                if (r_r.cnt == 32'(OFF2_CYC - 1))
                begin
                    r_nxt.fpo_n = 1'b0;
                    r_nxt.cnt   = 32'h0;
                    if (r_r.cyc)
                    begin
                        r_nxt.st = H_PWR_OFF;
                    end
                    else
                    begin
                        r_nxt.st   = H_IDLE;
                        r_nxt.done = 1'b1;
                    end
                end
            end
            H_PWR_OFF:
            begin
                // Residual charge must drain before power returns
                if (r_r.cnt == 32'(OFF_CYC - 1))
                begin
                    r_nxt.fpo_n = 1'b1;
                    r_nxt.cnt   = 32'h0;
                    r_nxt.st    = H_ON_RST;
                end
            end
            H_RST_HOLD:
            begin
                if (r_r.cnt == 32'(RST_CYC - 1))
                begin
                    r_nxt.rst_n = 1'b1;
                    r_nxt.st    = H_IDLE;
                    r_nxt.done  = 1'b1;
                end
            end
            default:
            begin
                r_nxt = HOST_RST;
            end
        endcase
    end

    // Power off, module reset and link reset all asserted after reset
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            r_r <= HOST_RST;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign busy_o               = (r_r.st != H_IDLE);
    assign done_o               = r_r.done;
    assign clkreq_seen_o        = r_r.ck_s[1];
    assign wake_seen_o          = r_r.wk_s[1];
    assign lnk.full_power_off_n = r_r.fpo_n;
    assign lnk.module_reset_n   = r_r.rst_n;
    assign lnk.perst_out        = r_r.perst_n;
    assign lnk.perst_oe_n       = 1'b0;
    assign lnk.h_clkreq_out     = 1'b0;
    assign lnk.h_clkreq_oe_n    = ~(r_r.own_clk | r_r.need);

endmodule
`default_nettype wire

//--- rtl/mpsq_pkg.sv
`default_nettype none
package mpsq_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned NS_PER_MS     = 1000000;
    localparam int unsigned CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned T_ON1_MS      = 8;
    localparam int unsigned T_ON2_MS      = 50;
    localparam int unsigned T_OFF1_MS     = 16;
    localparam int unsigned T_OFF2_MS     = 2;
    localparam int unsigned T_OFF_MS      = 500;
    localparam int unsigned T_RST_MS      = 2;
    localparam int unsigned MAX_GEN       = 2;
    localparam int unsigned LANES         = 1;

    // ==========================================================
    // Sequence requests
    // ==========================================================
    typedef enum logic [2:0] {
        SEQ_START     = 3'h0,
        SEQ_SHUTDOWN  = 3'h1,
        SEQ_RST_PWR   = 3'h2,
        SEQ_RST_KEEP  = 3'h3,
        SEQ_L2_ENTER  = 3'h4,
        SEQ_L2_EXIT   = 3'h5,
        SEQ_L12_ENTER = 3'h6,
        SEQ_L12_EXIT  = 3'h7
    } mpsq_seq_t;

    typedef enum logic [6:0] {
        H_IDLE     = 7'h01,
        H_ON_RST   = 7'h02,
        H_ON_PERST = 7'h04,
        H_OFF_RST  = 7'h08,
        H_OFF_FPO  = 7'h10,
        H_PWR_OFF  = 7'h20,
        H_RST_HOLD = 7'h40
    } mpsq_hst_t;

    // ==========================================================
    // State records
    // ==========================================================
    typedef struct packed {
        mpsq_hst_t   st;
        logic [31:0] cnt;
        logic        cyc;
        logic        fpo_n;
        logic        rst_n;
        logic        perst_n;
        logic        own_clk;
        logic        need;
        logic [1:0]  ck_s;
        logic [1:0]  wk_s;
        logic        done;
    } mpsq_host_st_t;

    localparam mpsq_host_st_t HOST_RST = '{st: H_IDLE, cnt: 32'h0, default: '0};

    typedef struct packed {
        logic [1:0] fpo_s;
        logic [1:0] rst_s;
        logic [1:0] perst_s;
        logic [1:0] ck_s;
        logic       pcie_rst;
        logic       mod_rst;
        logic       clk_drv;
        logic [1:0] drv_d;
        logic       wake_drv;
        logic       ck_seen;
        logic [1:0] gen;
    } mpsq_dev_st_t;

    localparam mpsq_dev_st_t DEV_RST = '{pcie_rst: 1'b1, mod_rst: 1'b1, gen: 2'h1,
                                         default: '0};

endpackage
`default_nettype wire

//--- rtl/mpsq_if.sv
`default_nettype none
interface mpsq_if;
    logic full_power_off_n;
    logic module_reset_n;
    logic perst_out;
    logic perst_oe_n;
    logic h_clkreq_out;
    logic h_clkreq_oe_n;
    logic d_clkreq_out;
    logic d_clkreq_oe_n;
    logic d_wake_out;
    logic d_wake_oe_n;
    logic perst_n;
    logic clkreq_n;
    logic link_wake_request_n;

    // Pull-ups on every shared line; an enabled low driver wins
    assign perst_n             = perst_oe_n | perst_out;
    assign clkreq_n            = (h_clkreq_oe_n | h_clkreq_out) & (d_clkreq_oe_n | d_clkreq_out);
    assign link_wake_request_n = d_wake_oe_n | d_wake_out;

    modport host (
        output full_power_off_n,
        output module_reset_n,
        output perst_out,
        output perst_oe_n,
        output h_clkreq_out,
        output h_clkreq_oe_n,
        input  clkreq_n,
        input  link_wake_request_n
    );

    modport dev (
        input  full_power_off_n,
        input  module_reset_n,
        input  perst_n,
        input  clkreq_n,
        output d_clkreq_out,
        output d_clkreq_oe_n,
        output d_wake_out,
        output d_wake_oe_n
    );
endinterface
`default_nettype wire

//--- rtl/mpsq_dev.sv
`default_nettype none
module mpsq_dev
    import mpsq_pkg::*;
#(
    parameter int unsigned GEN_MAX = MAX_GEN
)
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       tx_need_i,
    input  wire logic       wake_req_i,
    input  wire logic       coredump_i,
    input  wire logic [1:0] partner_gen_i,
    output logic            pcie_rst_o,
    output logic            module_rst_o,
    output logic            clkreq_seen_o,
    output logic [1:0]      link_gen_o,
    mpsq_if.dev             lnk
);

    mpsq_dev_st_t r_r;
    mpsq_dev_st_t r_nxt;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        r_nxt = r_r;
        r_nxt.fpo_s   = {r_r.fpo_s[0], lnk.full_power_off_n};
        r_nxt.rst_s   = {r_r.rst_s[0], lnk.module_reset_n};
        r_nxt.perst_s = {r_r.perst_s[0], lnk.perst_n};
        r_nxt.ck_s    = {r_r.ck_s[0], ~lnk.clkreq_n};
        r_nxt.pcie_rst = ~r_r.perst_s[1];
        // A core dump widens a fundamental reset to the whole module
        r_nxt.mod_rst = ~r_r.fpo_s[1] | ~r_r.rst_s[1]
                      | (coredump_i & ~r_r.perst_s[1]);
        r_nxt.clk_drv = tx_need_i & r_r.fpo_s[1];
        // Own drive is delayed to line up with the synchroniser, else
        // releasing it would look like the far side asserting
        r_nxt.drv_d   = {r_r.drv_d[0], r_r.clk_drv};
        r_nxt.ck_seen = r_r.ck_s[1] & ~r_r.drv_d[1];
        r_nxt.wake_drv = wake_req_i & r_r.fpo_s[1];
        if (partner_gen_i == 2'h0)
        begin
            r_nxt.gen = 2'h1;
        end
        else if (32'(partner_gen_i) > GEN_MAX)
        begin
            r_nxt.gen = 2'(GEN_MAX);
        end
        else
        begin
            r_nxt.gen = partner_gen_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            r_r <= DEV_RST;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign pcie_rst_o        = r_r.pcie_rst;
    assign module_rst_o      = r_r.mod_rst;
    assign clkreq_seen_o     = r_r.ck_seen;
    assign link_gen_o        = r_r.gen;
    assign lnk.d_clkreq_out  = 1'b0;
    assign lnk.d_clkreq_oe_n = ~r_r.clk_drv;
    assign lnk.d_wake_out    = 1'b0;
    assign lnk.d_wake_oe_n   = ~r_r.wake_drv;

endmodule
`default_nettype wire

//--- testbench/mpsq_monitor.sv
`default_nettype none
module mpsq_monitor #(
    parameter int ON1  = 8,
    parameter int ON2  = 50,
    parameter int OFF1 = 16,
    parameter int OFF2 = 2,
    parameter int OFF  = 50
)
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic full_power_off_n,
    input wire logic module_reset_n,
    input wire logic perst_n,
    input wire logic clkreq_n,
    input wire logic link_wake_request_n,
    input wire logic d_clkreq_oe_n,
    input wire logic d_wake_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int ON21  = ON2 - ON1;
    localparam int OFF12 = OFF1 + OFF2;
    localparam int OFF2P = OFF2 + 1;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // ==========================================================
    // Host sequencing
    // ==========================================================
    property p_on;
        $rose(full_power_off_n) |-> ##ON1 $rose(module_reset_n) ##ON21 $rose(perst_n);
    endproperty
    a_on: assert property (p_on)
        else $error("start-up release timing wrong");
    property p_last;
        $rose(perst_n) |-> full_power_off_n && module_reset_n;
    endproperty
    a_last: assert property (p_last)
        else $error("link reset released too early");
    property p_off;
        $fell(full_power_off_n) |->
            !$past(module_reset_n, OFF2) && $past(module_reset_n, OFF2P)
            && !$past(perst_n, OFF12);
    endproperty
    a_off: assert property (p_off)
        else $error("shutdown order or spacing wrong");
    // Only a powered module may see the short reset pulse
    property p_keep;
        $fell(module_reset_n) && full_power_off_n |-> !module_reset_n[*3];
    endproperty
    a_keep: assert property (p_keep)
        else $error("module reset pulse too short");
    property p_pcyc;
        $rose(full_power_off_n) |-> !$past(full_power_off_n, OFF);
    endproperty
    a_pcyc: assert property (p_pcyc)
        else $error("power-off gap too short");

    // ==========================================================
    // Device drives
    // ==========================================================
    property p_unpwr;
        !full_power_off_n[*4] |-> d_wake_oe_n && d_clkreq_oe_n;
    endproperty
    a_unpwr: assert property (p_unpwr)
        else $error("unpowered module drives a line");
    // Power is seen through a two-stage synchroniser and one register
    property p_ckod;
        $fell(d_clkreq_oe_n) |-> $past(full_power_off_n, 3) && !clkreq_n;
    endproperty
    a_ckod: assert property (p_ckod)
        else $error("clock request from unpowered module");
    property p_wkod;
        $fell(d_wake_oe_n) |-> $past(full_power_off_n, 3) && !link_wake_request_n;
    endproperty
    a_wkod: assert property (p_wkod)
        else $error("wake from unpowered module");
endmodule
`default_nettype wire

//--- testbench/mpsq_tb.sv
`default_nettype none
module mpsq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mpsq_pkg::*;

    localparam int ON1 = 8, ON2 = 50, OFF1 = 16, OFF2 = 2, OFF = 50, RST = 3;
    logic       core_clk_i = 1'h0;
    logic       rst_b_i    = 1'h0;
    logic       seq_req_i  = 1'h0;
    logic       clk_need_i = 1'h0;
    logic       tx_need_i  = 1'h0;
    logic       wake_req_i = 1'h0;
    logic       coredump_i = 1'h0;
    logic [1:0] partner_gen_i = 2'h2;
    mpsq_seq_t  seq_sel_i = SEQ_START;
    logic       busy_o, done_o, h_ck, h_wk, pcie_rst_o, module_rst_o, d_ck;
    logic [1:0] link_gen_o;
    int         failures = 0;
    int         num_checks = 0;

    always #5 core_clk_i = ~core_clk_i;

    mpsq_if lnk ();
    mpsq_host #(.ON1_CYC(ON1), .ON2_CYC(ON2), .OFF1_CYC(OFF1), .OFF2_CYC(OFF2),
        .OFF_CYC(OFF), .RST_CYC(RST)) mpsq_host_i (.core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i), .seq_req_i(seq_req_i), .seq_sel_i(seq_sel_i),
        .clk_need_i(clk_need_i), .busy_o(busy_o), .done_o(done_o),
        .clkreq_seen_o(h_ck), .wake_seen_o(h_wk), .lnk(lnk));
    mpsq_dev #(.GEN_MAX(2)) mpsq_dev_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .tx_need_i(tx_need_i), .wake_req_i(wake_req_i), .coredump_i(coredump_i),
        .partner_gen_i(partner_gen_i), .pcie_rst_o(pcie_rst_o),
        .module_rst_o(module_rst_o), .clkreq_seen_o(d_ck), .link_gen_o(link_gen_o),
        .lnk(lnk));
    mpsq_monitor #(.ON1(ON1), .ON2(ON2), .OFF1(OFF1), .OFF2(OFF2), .OFF(OFF))
        mpsq_monitor_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .full_power_off_n(lnk.full_power_off_n), .module_reset_n(lnk.module_reset_n),
        .perst_n(lnk.perst_n), .clkreq_n(lnk.clkreq_n),
        .link_wake_request_n(lnk.link_wake_request_n),
        .d_clkreq_oe_n(lnk.d_clkreq_oe_n), .d_wake_oe_n(lnk.d_wake_oe_n));

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic ck(input bit ok, input string msg);
        num_checks++;
        if (!ok)
        begin
            failures++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask

    task automatic conclude();
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    // Extra keeps the strobe up one more edge, selecting a request that must be dropped
    task automatic req(input mpsq_seq_t s, input int exp, input bit extra = 1'h0);
        int n;
        n = 0;
        seq_sel_i = s;
        seq_req_i = 1'h1;
        cyc(1);
        ck(busy_o === 1'(exp != 0), "busy level");
        if (extra)
        begin
            seq_sel_i = SEQ_L12_EXIT;
            cyc(1);
            n = 1;
        end
        seq_req_i = 1'h0;
        while (done_o !== 1'h1 && n < 2000)
        begin
            cyc(1);
            n++;
        end
        ck(n == exp, "sequence length");
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_start();
        ck(lnk.full_power_off_n === 1'h0 && lnk.module_reset_n === 1'h0, "safe");
        ck(lnk.perst_n === 1'h0 && pcie_rst_o === 1'h1, "link held");
        req(SEQ_START, ON2);
        ck(lnk.module_reset_n === 1'h1 && lnk.perst_n === 1'h1, "released");
        cyc(5);
        ck(pcie_rst_o === 1'h0 && module_rst_o === 1'h0, "device running");
    endtask

    task automatic t_gen();
        logic [1:0] gx [4];
        gx = '{2'h1, 2'h1, 2'h2, 2'h2};
        for (int g = 0; g < 4; g++)
        begin
            partner_gen_i = 2'(g);
            cyc(2);
            ck(link_gen_o === gx[g], "link generation");
        end
    endtask

    task automatic t_clk();
        tx_need_i = 1'h1;
        cyc(5);
        ck(h_ck === 1'h1 && d_ck === 1'h0, "device clock request");
        tx_need_i = 1'h0;
        clk_need_i = 1'h1;
        cyc(5);
        ck(d_ck === 1'h1, "host clock request");
        clk_need_i = 1'h0;
        req(SEQ_L12_EXIT, 0);
        cyc(5);
        ck(d_ck === 1'h1 && lnk.clkreq_n === 1'h0, "L1 exit");
        req(SEQ_L12_ENTER, 0);
        cyc(5);
        ck(lnk.clkreq_n === 1'h1 && d_ck === 1'h0, "L1.2 entry");
    endtask

    task automatic t_l2();
        req(SEQ_L2_ENTER, 0);
        cyc(5);
        ck(pcie_rst_o === 1'h1 && module_rst_o === 1'h0, "link reset only");
        wake_req_i = 1'h1;
        cyc(5);
        ck(h_wk === 1'h1 && lnk.link_wake_request_n === 1'h0, "wake");
        wake_req_i = 1'h0;
        cyc(5);
        ck(h_wk === 1'h0 && lnk.link_wake_request_n === 1'h1, "wake off");
        coredump_i = 1'h1;
        cyc(5);
        ck(module_rst_o === 1'h1, "core dump reset");
        req(SEQ_L2_EXIT, 0);
        coredump_i = 1'h0;
        cyc(5);
        ck(pcie_rst_o === 1'h0 && module_rst_o === 1'h0, "link back");
    endtask

    task automatic t_resets();
        req(SEQ_RST_KEEP, RST);
        ck(lnk.perst_n === 1'h1 && lnk.full_power_off_n === 1'h1, "kept");
        req(SEQ_RST_PWR, OFF1 + OFF2 + OFF + ON2);
        ck(lnk.full_power_off_n === 1'h1 && lnk.perst_n === 1'h1, "cycled");
    endtask

    task automatic t_down();
        tx_need_i = 1'h1;
        req(SEQ_SHUTDOWN, OFF1 + OFF2, 1'h1);
        ck(lnk.module_reset_n === 1'h0 && lnk.perst_n === 1'h0, "shut down");
        cyc(5);
        ck(lnk.clkreq_n === 1'h1 && module_rst_o === 1'h1, "unpowered");
        tx_need_i = 1'h0;
        cyc(60);
    endtask

    initial
    begin
        cyc(10);
        rst_b_i = 1'h1;
        cyc(60);
        t_start();
        t_gen();
        t_clk();
        t_l2();
        t_resets();
        t_down();
        conclude();
    end

    initial
    begin
        #50000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
